// ===== inc/hsmc_cfg.svh
// Constants of the host shared-memory cache: depths, widths and steps.
// Assumes inclusion by bare name from the package and the design files.
`ifndef HSMC_CFG_SVH
`define HSMC_CFG_SVH

// ---------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------
`define HSMC_FIFO_DEPTH 4
`define HSMC_ADDR_W 16
`define HSMC_BYTE_W 8

// ---------------------------------------------------------------------
// Counter steps and reset values
// ---------------------------------------------------------------------
`define HSMC_STEP_BYTE 2'h1
`define HSMC_STEP_WORD 2'h2
`define HSMC_SYNC_IDLE 3'h7
`define HSMC_BYTE_ZERO 8'h00
`define HSMC_WORD_ZERO 16'h0000

`endif

// ===== inc/hsmc_pkg.sv
// Types shared by the host shared-memory cache files.
// Assumes hsmc_cfg.svh is on the include path.
`include "hsmc_cfg.svh"

package hsmc_pkg;

  // -------------------------------------------------------------------
  // Host access sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    HSMC_IDLE = 2'b00,
    HSMC_EVAL = 2'b01,
    HSMC_WAIT = 2'b10,
    HSMC_DONE = 2'b11
  } hsmc_state_t;

  // Direction the FIFO currently serves
  typedef enum logic {
    HSMC_MODE_READ = 1'b0,
    HSMC_MODE_WRITE = 1'b1
  } hsmc_mode_t;

endpackage

// ===== hdl/hsmc_fifo_mem.sv
// Byte storage of the cache FIFO: two write ports, two registered reads.
// Assumes the caller never writes both ports to one address in a cycle.
`timescale 1ns/10ps
`default_nettype none
`include "hsmc_cfg.svh"

module hsmc_fifo_mem #(
  parameter int W = `HSMC_BYTE_W,
  parameter int DEPTH = `HSMC_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we0,
  input wire logic [AW-1:0] wa0,
  input wire logic [W-1:0] wd0,
  input wire logic we1,
  input wire logic [AW-1:0] wa1,
  input wire logic [W-1:0] wd1,
  input wire logic [AW-1:0] ra0,
  input wire logic [AW-1:0] ra1,
  output logic [W-1:0] rd0,
  output logic [W-1:0] rd1
);
  import hsmc_pkg::*;

  logic [W-1:0] mem [DEPTH];

  // ---------------------------------------------------------------------
  // Storage; cleared so that no unknown byte ever reaches the RAM pins
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      if (we0) begin
        mem[wa0] <= wd0;
      end
      if (we1) begin
        mem[wa1] <= wd1;
      end
    end
  end

  // Read data one cycle after the address, from flip-flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd0 <= '0;
      rd1 <= '0;
    end else begin
      rd0 <= mem[ra0];
      rd1 <= mem[ra1];
    end
  end

endmodule
`default_nettype wire

// ===== hdl/hsmc_cache.sv
// Host shared-memory cache: four-byte FIFO between host strobes and RAM.
// Assumes a byte-wide buffer RAM answering ram_req with a one-cycle ram_ack.
`timescale 1ns/10ps
`default_nettype none
`include "hsmc_cfg.svh"

module hsmc_cache #(
  parameter int ADDR_W = `HSMC_ADDR_W,
  parameter int DEPTH = `HSMC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_word,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic iordy_out,
  output logic iordy_oe,
  output logic no_wait_response_n,
  input wire logic wide_mem_enable,
  input wire logic slot16,
  input wire logic no_wait_allow,
  input wire logic stagger_fix,
  output logic [ADDR_W-1:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_req,
  output logic ram_we,
  input wire logic ram_ack,
  input wire logic [7:0] ram_rdata
);
  import hsmc_pkg::*;

  localparam int MW = $clog2(DEPTH);
  localparam int PW = MW + 1;
  localparam logic [PW-1:0] FULL = PW'(DEPTH);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  // Byte count of one host access
  function automatic logic [1:0] step_of(input logic word);
    step_of = word ? `HSMC_STEP_WORD : `HSMC_STEP_BYTE;
  endfunction

  // ---------------------------------------------------------------------
  // Strobe synchronisers
  // ---------------------------------------------------------------------
  logic [2:0] rd_sync;
  logic [2:0] wr_sync;
  logic rd_lvl_n;
  logic wr_lvl_n;

  // A level moves only when the second and third stages agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_sync <= `HSMC_SYNC_IDLE;
      wr_sync <= `HSMC_SYNC_IDLE;
      rd_lvl_n <= 1'h1;
      wr_lvl_n <= 1'h1;
    end else begin
      rd_sync <= {rd_sync[1:0], host_rd_n};
      wr_sync <= {wr_sync[1:0], host_wr_n};
      if (rd_sync[1] == rd_sync[2]) begin
        rd_lvl_n <= rd_sync[2];
      end
      if (wr_sync[1] == wr_sync[2]) begin
        wr_lvl_n <= wr_sync[2];
      end
    end
  end

  wire strobe_act = !rd_lvl_n || !wr_lvl_n;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  hsmc_state_t state;
  hsmc_state_t next_state;
  hsmc_mode_t mode;
  logic [ADDR_W-1:0] host_cnt;
  logic [ADDR_W-1:0] buf_cnt;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [ADDR_W-1:0] cap_addr;
  logic cap_word;
  logic cap_wr;
  logic [15:0] cap_wdata;
  logic zw_hold;
  logic drove;
  logic stable;
  logic [7:0] mem_rd0;
  logic [7:0] mem_rd1;

  // ---------------------------------------------------------------------
  // Decode of the pending access
  // ---------------------------------------------------------------------
  wire busy = (state == HSMC_EVAL) || (state == HSMC_WAIT);
  wire [PW-1:0] count = wr_ptr - rd_ptr;
  wire [PW-1:0] need = PW'(step_of(cap_word));
  wire addr_hit = cap_addr == host_cnt;
  wire in_write = mode == HSMC_MODE_WRITE;
  wire mode_match = cap_wr == in_write;
  wire miss = !addr_hit || !mode_match;
  // Write mode must be empty before reloading; read prefetch is discarded
  wire can_load = !in_write || (count == '0);
  wire do_load = busy && miss && can_load;
  // Fresh read data needs an unmoved pointer and no write last cycle
  wire rd_ready = !cap_wr && count >= need && stable;
  wire wr_room = cap_wr && (FULL - count) >= need;
  wire do_serve = busy && !miss && (rd_ready || wr_room);
  wire host_end = (state == HSMC_DONE) && !strobe_act;

  // Zero-wait choice, taken once as the access is first seen
  wire width_ok = !cap_word || (wide_mem_enable && slot16);
  wire cache_ok = !miss && (rd_ready || wr_room);
  wire write_free = cap_wr && (!in_write || count == '0);
  wire zw_ok = no_wait_allow && width_ok && (cache_ok || write_free);

  // ---------------------------------------------------------------------
  // RAM side requests
  // ---------------------------------------------------------------------
  // Prefetch runs while room remains; drain while bytes are held
  wire fill_req = !in_write && count < FULL;
  wire drain_req = in_write && count != '0 && stable;
  assign ram_req = !do_load && (fill_req || drain_req);
  assign ram_we = in_write;
  assign ram_addr = buf_cnt;
  assign ram_wdata = mem_rd0;
  wire fill_ack = ram_req && ram_ack && !in_write;
  wire drain_ack = ram_req && ram_ack && in_write;

  // ---------------------------------------------------------------------
  // FIFO write ports: RAM fill in read mode, host data in write mode
  // ---------------------------------------------------------------------
  wire host_wr = do_serve && cap_wr;
  wire we0 = fill_ack || host_wr;
  wire we1 = host_wr && cap_word;
  wire [MW-1:0] wa0 = wr_ptr[MW-1:0];
  wire [MW-1:0] wa1 = MW'(wr_ptr + PTR_ONE);
  wire [7:0] wd0 = in_write ? cap_wdata[7:0] : ram_rdata;
  wire [MW-1:0] ra1 = MW'(rd_ptr + PTR_ONE);

  hsmc_fifo_mem #(
    .W(`HSMC_BYTE_W),
    .DEPTH(DEPTH),
    .AW(MW)
  ) u_mem (
    .clk(clk),
    .nrst(nrst),
    .we0(we0),
    .wa0(wa0),
    .wd0(wd0),
    .we1(we1),
    .wa1(wa1),
    .wd1(cap_wdata[15:8]),
    .ra0(rd_ptr[MW-1:0]),
    .ra1(ra1),
    .rd0(mem_rd0),
    .rd1(mem_rd1)
  );

  // ---------------------------------------------------------------------
  // Pointer next values
  // ---------------------------------------------------------------------
  // Each pointer has one mover per mode, so they never collide
  assign next_wr_ptr = do_load ? '0 :
                       fill_ack ? wr_ptr + PTR_ONE :
                       (host_end && in_write) ? wr_ptr + need : wr_ptr;
  assign next_rd_ptr = do_load ? '0 :
                       drain_ack ? rd_ptr + PTR_ONE :
                       (host_end && !in_write) ? rd_ptr + need : rd_ptr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      stable <= 1'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      stable <= (next_rd_ptr == rd_ptr) && !we0 && !we1;
    end
  end

  // ---------------------------------------------------------------------
  // Address counters and mode
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_cnt <= '0;
      buf_cnt <= '0;
      mode <= HSMC_MODE_READ;
    end else if (do_load) begin
      host_cnt <= cap_addr;
      buf_cnt <= {cap_addr[ADDR_W-1:1], cap_addr[0] | stagger_fix};
      mode <= cap_wr ? HSMC_MODE_WRITE : HSMC_MODE_READ;
    end else begin
      if (host_end) begin
        host_cnt <= host_cnt + ADDR_W'(step_of(cap_word));
      end
      if (fill_ack || drain_ack) begin
        buf_cnt <= buf_cnt + ADDR_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Host access sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      HSMC_IDLE: begin
        if (strobe_act) begin
          next_state = HSMC_EVAL;
        end
      end
      HSMC_EVAL, HSMC_WAIT: begin
        if (!strobe_act) begin
          next_state = HSMC_IDLE;
        end else if (do_serve) begin
          next_state = HSMC_DONE;
        end else begin
          next_state = HSMC_WAIT;
        end
      end
      HSMC_DONE: begin
        if (!strobe_act) begin
          next_state = HSMC_IDLE;
        end
      end
    endcase
  end

  // Capture the pin bus once the synchronised strobe is seen
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= HSMC_IDLE;
      cap_addr <= '0;
      cap_word <= 1'h0;
      cap_wr <= 1'h0;
      cap_wdata <= `HSMC_WORD_ZERO;
    end else begin
      state <= next_state;
      if (state == HSMC_IDLE && strobe_act) begin
        cap_addr <= host_addr;
        cap_word <= host_word;
        cap_wr <= !wr_lvl_n;
        cap_wdata <= host_wdata;
      end
    end
  end

  // Read data latched as the access is served; byte reads zero-extend
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_rdata <= `HSMC_WORD_ZERO;
    end else if (do_serve && !cap_wr) begin
      host_rdata <= {cap_word ? mem_rd1 : `HSMC_BYTE_ZERO, mem_rd0};
    end
  end

  // Zero-wait flag held for the rest of the access; drove marks a stall
  always_ff @(posedge clk) begin
    if (!nrst) begin
      zw_hold <= 1'h0;
      drove <= 1'h0;
    end else if (state == HSMC_IDLE) begin
      zw_hold <= 1'h0;
      drove <= 1'h0;
    end else begin
      if (state == HSMC_EVAL) begin
        zw_hold <= zw_ok;
      end
      if (state == HSMC_WAIT && !zw_hold) begin
        drove <= 1'h1;
      end
    end
  end

  assign no_wait_response_n = !zw_hold;

  // ---------------------------------------------------------------------
  // IORDY pin: low while stalled, high once ready after a stall, off otherwise
  // ---------------------------------------------------------------------
  // Driver stays off on zero-wait accesses, even while one waits in HSMC_WAIT
  assign iordy_out = state == HSMC_DONE;
  assign iordy_oe = (state == HSMC_WAIT && !zw_hold) || (state == HSMC_DONE && drove);

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_depth;
    count <= FULL;
  endproperty
  a_depth: assert property (p_depth) else $error("FIFO holds more than its depth");

  property p_load;
    do_load |=> host_cnt == $past(cap_addr) && buf_cnt[ADDR_W-1:1] == $past(cap_addr[ADDR_W-1:1]);
  endproperty
  a_load: assert property (p_load) else $error("Counters not loaded on miss");

  property p_fill;
    fill_ack && !do_load && !host_end |=>
      buf_cnt == $past(buf_cnt) + ADDR_W'(1) && count == $past(count) + PTR_ONE;
  endproperty
  a_fill: assert property (p_fill) else $error("Fill did not advance counter");

  property p_stall;
    state == HSMC_WAIT && !zw_hold |-> iordy_oe && !iordy_out;
  endproperty
  a_stall: assert property (p_stall) else $error("IORDY not low during stall");

  property p_advance;
    host_end |=> host_cnt == $past(host_cnt) + ADDR_W'($past(need));
  endproperty
  a_advance: assert property (p_advance) else $error("Host counter step wrong");

  property p_prefetch;
    !in_write && count < FULL && !busy |-> ram_req;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("Prefetch stopped with room");

  property p_hit;
    state == HSMC_EVAL && strobe_act && do_serve |=> state == HSMC_DONE ##0 !iordy_oe;
  endproperty
  a_hit: assert property (p_hit) else $error("Hit was stalled");

  property p_flush;
    do_load && in_write |-> count == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("Reload before write flush");

  property p_release;
    state == HSMC_DONE && !strobe_act |=> !iordy_oe;
  endproperty
  a_release: assert property (p_release) else $error("IORDY held after strobe end");

  property p_allow;
    !no_wait_allow && state == HSMC_EVAL |=> no_wait_response_n;
  endproperty
  a_allow: assert property (p_allow) else $error("Zero-wait given while disallowed");

  property p_stagger;
    do_load && stagger_fix |=> buf_cnt[0];
  endproperty
  a_stagger: assert property (p_stagger) else $error("Stagger fix bit not forced");

endmodule
`default_nettype wire

// ===== sim/hsmc_ram_model.sv
// Behavioural byte-wide buffer RAM that answers the cache's request port.
// Assumes one clock shared with the cache and a request held until acknowledged.
`timescale 1ns/10ps
`default_nettype none

module hsmc_ram_model #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [3:0] lat,
  output logic ram_ack,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:(2**ADDR_W)-1];
  logic [3:0] wcnt;
  logic [7:0] last;

  // -------------------------------------------------------------------
  // Contents and answer
  // -------------------------------------------------------------------
  // Preload a pattern the bench can recompute for any address
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    end
  end

  // Ack after lat waiting cycles; outside an ack the data bus shows junk
  assign ram_ack = ram_req && (wcnt >= lat);
  assign ram_rdata = ram_ack ? mem[ram_addr] : ~last;

  // Waiting count, write commit and last value seen on the bus
  always @(posedge clk) begin
    if (!nrst) begin
      wcnt <= 4'h0;
      last <= 8'h00;
    end else if (ram_ack) begin
      wcnt <= 4'h0;
      if (ram_we) mem[ram_addr] <= ram_wdata;
      else last <= mem[ram_addr];
    end else if (ram_req) begin
      wcnt <= wcnt + 4'h1;
    end else begin
      wcnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/hsmc_cache_tb.sv
// Self-checking bench for the cache: host strobes driven here, RAM modelled.
// Assumes the cache and RAM model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none

module hsmc_cache_tb;
  logic clk, nrst, host_rd_n, host_wr_n, host_word;
  logic [15:0] host_addr, host_wdata, host_rdata, ram_addr;
  logic iordy_out, iordy_oe, no_wait_response_n, ram_req, ram_we, ram_ack;
  logic wide_mem_enable, slot16, no_wait_allow, stagger_fix;
  logic [7:0] ram_wdata, ram_rdata;
  logic [3:0] lat;
  logic [15:0] rd;
  logic st, zw;
  int n_mismatch, n_compared;

  // -------------------------------------------------------------------
  // Structure
  // -------------------------------------------------------------------
  hsmc_cache DUT (.clk(clk), .nrst(nrst), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_word(host_word), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .iordy_out(iordy_out), .iordy_oe(iordy_oe),
    .no_wait_response_n(no_wait_response_n), .wide_mem_enable(wide_mem_enable),
    .slot16(slot16), .no_wait_allow(no_wait_allow), .stagger_fix(stagger_fix),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_req(ram_req), .ram_we(ram_we),
    .ram_ack(ram_ack), .ram_rdata(ram_rdata));

  hsmc_ram_model u_ram (.clk(clk), .nrst(nrst), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_req(ram_req), .ram_we(ram_we), .lat(lat), .ram_ack(ram_ack), .ram_rdata(ram_rdata));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    n_mismatch++;
    $display("ERROR %s expected done seen hang", what);
    complete_run();
  endtask

  // One host cycle: hold the strobe a bus cycle, longer while the board stalls
  task automatic host_op(input logic wr, input logic wd, input logic [15:0] a,
                         input logic [15:0] d);
    int n;
    @(negedge clk);
    host_addr = a;
    host_word = wd;
    host_wdata = d;
    if (wr) host_wr_n = 1'b0;
    else host_rd_n = 1'b0;
    st = 1'b0;
    zw = 1'b0;
    n = 0;
    while (n < 12 || (iordy_oe === 1'b1 && iordy_out === 1'b0)) begin
      @(negedge clk);
      n++;
      if (iordy_oe === 1'b1 && iordy_out === 1'b0) st = 1'b1;
      if (no_wait_response_n === 1'b0) zw = 1'b1;
      if (n > 400) give_up("iordy");
    end
    rd = host_rdata;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    n = 0;
    while (iordy_oe !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 20) give_up("iordy_oe");
    end
    check("iordy_oe", {15'h0000, iordy_oe}, 16'h0000);
    repeat (4) @(negedge clk);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // Word read miss with a slow RAM stalls, then returns both bytes
  task automatic t_read_miss();
    lat = 4'h2;
    host_op(1'b0, 1'b1, 16'h0100, 16'h0000);
    check("miss stall", {15'h0000, st}, 16'h0001);
    check("miss data", rd, {pat(16'h0101), pat(16'h0100)});
    lat = 4'h0;
    repeat (10) @(negedge clk);
  endtask

  // Sequential hits: word, two bytes, all served without stall
  task automatic t_hits();
    host_op(1'b0, 1'b1, 16'h0102, 16'h0000);
    check("hit stall", {15'h0000, st}, 16'h0000);
    check("hit data", rd, {pat(16'h0103), pat(16'h0102)});
    check("hit no wait", {15'h0000, zw}, 16'h0001);
    host_op(1'b0, 1'b0, 16'h0104, 16'h0000);
    check("byte data", rd, {8'h00, pat(16'h0104)});
    check("byte no wait", {15'h0000, zw}, 16'h0001);
    host_op(1'b0, 1'b0, 16'h0105, 16'h0000);
    check("byte step", {15'h0000, st}, 16'h0000);
    check("byte step data", rd, {8'h00, pat(16'h0105)});
  endtask

  // Zero-wait withheld when not allowed or, for words, when wide memory is off
  task automatic t_no_wait_off();
    no_wait_allow = 1'b0;
    host_op(1'b0, 1'b1, 16'h0106, 16'h0000);
    check("allow off", {15'h0000, zw}, 16'h0000);
    check("allow off data", rd, {pat(16'h0107), pat(16'h0106)});
    no_wait_allow = 1'b1;
    wide_mem_enable = 1'b0;
    host_op(1'b0, 1'b1, 16'h0108, 16'h0000);
    check("narrow word", {15'h0000, zw}, 16'h0000);
    wide_mem_enable = 1'b1;
    // An 8-bit slot withholds zero-wait from words but not from bytes
    slot16 = 1'b0;
    host_op(1'b0, 1'b1, 16'h010a, 16'h0000);
    check("slot8 word", {15'h0000, zw}, 16'h0000);
    host_op(1'b0, 1'b0, 16'h010c, 16'h0000);
    check("slot8 byte", {15'h0000, zw}, 16'h0001);
    check("slot8 byte data", rd, {8'h00, pat(16'h010c)});
    slot16 = 1'b1;
  endtask

  // Posted writes, a write miss that drains, then a read that flushes
  task automatic t_writes();
    host_op(1'b1, 1'b1, 16'h0200, 16'hbeef);
    check("write in read mode", {15'h0000, zw}, 16'h0001);
    // Slow RAM keeps posted bytes pending when the next miss arrives
    lat = 4'hf;
    host_op(1'b1, 1'b1, 16'h0202, 16'hc0de);
    check("write hit", {15'h0000, zw}, 16'h0001);
    host_op(1'b1, 1'b1, 16'h0300, 16'h1234);
    check("write miss stall", {15'h0000, st}, 16'h0001);
    check("drain lo", {u_ram.mem[16'h0201], u_ram.mem[16'h0200]}, 16'hbeef);
    check("drain hi", {u_ram.mem[16'h0203], u_ram.mem[16'h0202]}, 16'hc0de);
    host_op(1'b0, 1'b1, 16'h0300, 16'h0000);
    check("flush stall", {15'h0000, st}, 16'h0001);
    check("read back", rd, 16'h1234);
    lat = 4'h0;
  endtask

  // Stagger fix shifts the buffer side to the odd byte on a miss
  task automatic t_stagger();
    stagger_fix = 1'b1;
    host_op(1'b0, 1'b1, 16'h0400, 16'h0000);
    check("stagger data", rd, {pat(16'h0402), pat(16'h0401)});
    stagger_fix = 1'b0;
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    nrst = 1'b0;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_word = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
    wide_mem_enable = 1'b1;
    slot16 = 1'b1;
    no_wait_allow = 1'b1;
    stagger_fix = 1'b0;
    lat = 4'h0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    t_read_miss();
    t_hits();
    t_no_wait_off();
    t_writes();
    t_stagger();
    complete_run();
  end
endmodule
`default_nettype wire
